//--- hw/depm_channel.v
// One sensor channel: decode, direction, offset, scale and speed
`timescale 1ns/10ps
`include "depm_defines.vh"

module depm_channel #(
	parameter W = 32
) (
	// Clock and control
	input  wire         clk_i,
	input  wire         rst_n_i,
	input  wire         ce_i,
	input  wire         tick_i,
	// Configuration
	input  wire [2:0]   type_i,
	input  wire [1:0]   fmt_i,
	input  wire [5:0]   width_i,
	input  wire         dir_inv_i,
	input  wire [W-1:0] offset_i,
	input  wire [15:0]  pos_factor_i,
	input  wire [4:0]   pos_shift_i,
	input  wire [15:0]  spd_factor_i,
	input  wire [4:0]   spd_shift_i,
	input  wire [2:0]   filt_log2_i,
	// Sensor inputs
	input  wire         trk_a_i,
	input  wire         trk_b_i,
	input  wire [W-1:0] abs_word_i,
	// Results
	output reg  [W-1:0] pos_o,
	output reg  [W-1:0] spd_o
);

	reg         a_d;
	reg         b_d;
	reg [W-1:0] count;
	reg [W-1:0] last_raw;
	reg [W-1:0] acc;
	reg [4:0]   n_avg;

	// Gray to binary, masked to the word width
	function [W-1:0] depm_decode;
		input [W-1:0] w;
		input [1:0]   f;
		input [5:0]   wd;
		integer       k;
		reg   [W-1:0] g;
		reg   [W-1:0] m;
		begin
			m = {W{1'b1}};
			if (wd != 6'h0 && wd < W)
				m = ~({W{1'b1}} << wd);
			g = w & m;
			if (f == `DEPM_FMT_GRAY) begin
				for (k = W - 2; k >= 0; k = k - 1)
					g[k] = g[k] ^ g[k+1];
			end
			depm_decode = g;
		end
	endfunction

	// Factor times value, then power-of-two shift
	function [W-1:0] depm_scale;
		input [W-1:0] v;
		input [15:0]  f;
		input [4:0]   s;
		reg   [W+15:0] p;
		begin
			p = $signed(v) * $signed({1'b0, f});
			// Shift the full product so the sign survives, then keep W bits
			p = $signed(p) >>> s;
			depm_scale = p[W-1:0];
		end
	endfunction

	wire [5:0]   eff_w  = (fmt_i == `DEPM_FMT_VCODED) ? `DEPM_VCODED_WIDTH : width_i;
	wire [W-1:0] abs_v  = depm_decode(abs_word_i, fmt_i, eff_w);
	wire         is_abs = (type_i == `DEPM_TYPE_ABS);
	// Edge multiplication follows type: x4 quadrature, x1 single track
	wire         ea     = trk_a_i ^ a_d;
	wire         eb     = trk_b_i ^ b_d;
	wire         quad   = (type_i == `DEPM_TYPE_INCR) || (type_i == `DEPM_TYPE_SINCOS)
	                      || (type_i == `DEPM_TYPE_SWQ);
	wire         fwd    = trk_a_i ^ b_d;
	wire         step_q = quad && (ea || eb);
	wire         step_1 = (type_i == `DEPM_TYPE_SW1) && trk_a_i && !a_d;
	wire         up     = (step_1 ? 1'b1 : fwd) ^ dir_inv_i;
	wire [W-1:0] raw    = is_abs ? (dir_inv_i ? (~abs_v + 1'b1) : abs_v) + offset_i
	                             : count;
	wire [W-1:0] delta  = raw - last_raw;

	// Counting runs every enabled clock; position and speed are only taken per module cycle
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			a_d      <= 1'b0;
			b_d      <= 1'b0;
			count    <= {W{1'b0}};
			last_raw <= {W{1'b0}};
			acc      <= {W{1'b0}};
			n_avg    <= 5'h0;
			pos_o    <= {W{1'b0}};
			spd_o    <= {W{1'b0}};
		end else if (ce_i) begin
			a_d <= trk_a_i;
			b_d <= trk_b_i;
			if (step_q || step_1)
				count <= up ? count + 1'b1 : count - 1'b1;
			if (tick_i) begin
				last_raw <= raw;
				pos_o    <= depm_scale(raw, pos_factor_i, pos_shift_i);
				// Moving average by block sum; adds the window to response time
				if (filt_log2_i == 3'h0) begin
					spd_o <= depm_scale(delta, spd_factor_i, spd_shift_i);
				end else if (n_avg == ((5'h1 << filt_log2_i) - 5'h1)) begin
					spd_o <= depm_scale($signed(acc + delta) >>> filt_log2_i,
					                    spd_factor_i, spd_shift_i);
					acc   <= {W{1'b0}};
					n_avg <= 5'h0;
				end else begin
					acc   <= acc + delta;
					n_avg <= n_avg + 5'h1;
				end
			end
		end
	end

endmodule // depm_channel

//--- hw/depm_defines.vh
// Constants shared by the dual encoder plausibility monitor
`ifndef DEPM_DEFINES_VH
`define DEPM_DEFINES_VH

// Sensor type codes
`define DEPM_TYPE_NONE      3'h0
`define DEPM_TYPE_INCR      3'h1
`define DEPM_TYPE_SINCOS    3'h2
`define DEPM_TYPE_ABS       3'h3
`define DEPM_TYPE_SW1       3'h4
`define DEPM_TYPE_SWQ       3'h5

// Absolute data formats
`define DEPM_FMT_BIN        2'h0
`define DEPM_FMT_GRAY       2'h1
`define DEPM_FMT_VCODED     2'h2

// Fixed word width of the vendor coded serial format
`define DEPM_VCODED_WIDTH   6'h18

// Measuring section kind
`define DEPM_SECT_LINEAR    1'b0
`define DEPM_SECT_ROTARY    1'b1

// Position units: mm, milli-degree, revolution
`define DEPM_PUNIT_MM       2'h0
`define DEPM_PUNIT_MDEG     2'h1
`define DEPM_PUNIT_REV      2'h2

// Speed units: mm/s, m/s, mdeg/s, rev/s, rev/min
`define DEPM_VUNIT_MMS      3'h0
`define DEPM_VUNIT_MS       3'h1
`define DEPM_VUNIT_MDEGS    3'h2
`define DEPM_VUNIT_REVS     3'h3
`define DEPM_VUNIT_REVM     3'h4

// Monitor states
`define DEPM_ST_IDLE        2'h0
`define DEPM_ST_RUN         2'h1
`define DEPM_ST_ALARM       2'h2

// Filter window length, log2 of the longest window
`define DEPM_FILT_LOG2      3'h4

// Module cycle in clock periods
`define DEPM_CYCLE_NS       1000
`define DEPM_CLK_NS         100
`define DEPM_CYCLE_CLKS     (`DEPM_CYCLE_NS / `DEPM_CLK_NS)

`endif

//--- hw/depm_monitor.v
// Dual encoder plausibility monitor: limits, consistency, alarm
// Summary of operation
// - Linear section reports position in mm, speed in mm/s or m/s.
// - Rotary section reports mdeg or rev; speed mdeg/s, rev/s or rev/min.
// - Position processing only with an absolute sensor; gates position monitors.
// - Active position outside measuring length raises axis alarm.
// - Speed above maximum raises fault alarm with shut-down and error status.
// - Alarm forces every safety output off.
// - Channel speed or position deviation beyond threshold trips consistency.
// - Consistency thresholds scale up with configured maximum speed.
// - Optional moving average smooths speed, adding its window to response.
// - Sensor one is process, two reference; a sole absolute sensor is always process.
// - Sensor types: none, incremental, sin/cos, absolute, two switch kinds.
// - Absolute words decoded binary or gray; vendor coded format fixed width.
// - Configured offset added to each absolute reading.
// - Per-sensor direction selects count up or down.
// - Incremental edge multiplication chosen from sensor configuration.
// - Speed limit offered to monitors is maximum speed times one and a half.
// - Normalisation uses factor and power-of-two shift, position and speed.
`timescale 1ns/10ps
`include "depm_defines.vh"

module depm_monitor #(
	parameter W          = 32,
	parameter NOUT       = 8,
	parameter CYCLE_CLKS = `DEPM_CYCLE_CLKS
) (
	// Clock, reset, enable
	input  wire            clk_i,
	input  wire            rst_n_i,
	input  wire            ce_i,
	// Measuring section
	input  wire            sect_rotary_i,
	input  wire [1:0]      pos_unit_i,
	input  wire [2:0]      spd_unit_i,
	input  wire            pos_proc_en_i,
	input  wire [W-1:0]    meas_length_i,
	input  wire [W-1:0]    max_speed_i,
	input  wire [W-1:0]    thr_pos_i,
	input  wire [W-1:0]    thr_spd_i,
	input  wire [2:0]      filt_log2_i,
	// Sensor one configuration
	input  wire [2:0]      s1_type_i,
	input  wire [1:0]      s1_fmt_i,
	input  wire [5:0]      s1_width_i,
	input  wire            s1_dir_inv_i,
	input  wire [W-1:0]    s1_offset_i,
	input  wire [15:0]     s1_position_norm_factor_i,
	input  wire [4:0]      s1_position_shift_exponent_i,
	input  wire [15:0]     s1_speed_norm_factor_i,
	input  wire [4:0]      s1_speed_shift_exponent_i,
	// Sensor two configuration
	input  wire [2:0]      s2_type_i,
	input  wire [1:0]      s2_fmt_i,
	input  wire [5:0]      s2_width_i,
	input  wire            s2_dir_inv_i,
	input  wire [W-1:0]    s2_offset_i,
	input  wire [15:0]     s2_position_norm_factor_i,
	input  wire [4:0]      s2_position_shift_exponent_i,
	input  wire [15:0]     s2_speed_norm_factor_i,
	input  wire [4:0]      s2_speed_shift_exponent_i,
	// Sensor inputs
	input  wire            s1_trk_a_i,
	input  wire            s1_trk_b_i,
	input  wire [W-1:0]    s1_abs_word_i,
	input  wire            s2_trk_a_i,
	input  wire            s2_trk_b_i,
	input  wire [W-1:0]    s2_abs_word_i,
	// Safety outputs requested by downstream logic
	input  wire [NOUT-1:0] out_req_i,
	// Results and status
	output reg  [NOUT-1:0] safe_out_o,
	output reg  [W-1:0]    proc_pos_o,
	output reg  [W-1:0]    proc_spd_o,
	output reg  [W-1:0]    spd_limit_o,
	output reg             pos_mon_active_o,
	output reg             sect_rotary_o,
	output reg  [1:0]      pos_unit_o,
	output reg  [2:0]      spd_unit_o,
	output reg             alarm_o,
	output reg             err_range_o,
	output reg             err_overspeed_o,
	output reg             err_consist_o,
	output reg             cfg_error_o
);

	reg        rst_s1;
	reg        rst_s2;
	reg [1:0]  state;
	reg [1:0]  next_state;
	reg [15:0] cyc_cnt;
	reg        tick;

	wire [W-1:0] c1_pos;
	wire [W-1:0] c1_spd;
	wire [W-1:0] c2_pos;
	wire [W-1:0] c2_spd;

	// Released reset copy
	wire rst_n = rst_s2;

	// Magnitude of a signed word
	function [W-1:0] depm_abs;
		input [W-1:0] v;
		begin
			depm_abs = v[W-1] ? (~v + 1'b1) : v;
		end
	endfunction

	// Two flop reset release; the async assert still acts at once
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_s1 <= 1'b0;
			rst_s2 <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_s2 <= rst_s1;
		end
	end

	// Module cycle tick
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cyc_cnt <= 16'h0;
			tick    <= 1'b0;
		end else if (ce_i) begin
			tick <= (cyc_cnt == CYCLE_CLKS[15:0] - 16'h1);
			if (cyc_cnt == CYCLE_CLKS[15:0] - 16'h1)
				cyc_cnt <= 16'h0;
			else
				cyc_cnt <= cyc_cnt + 16'h1;
		end
	end

	// Sensor one as process unless only sensor two is absolute
	wire s1_abs = (s1_type_i == `DEPM_TYPE_ABS);
	wire s2_abs = (s2_type_i == `DEPM_TYPE_ABS);
	wire swap   = s2_abs && !s1_abs;
	// Position processing needs an absolute sensor
	wire pos_act = pos_proc_en_i && (s1_abs || s2_abs);

	// Unit legality per section kind
	wire unit_ok = sect_rotary_i ?
	               ((pos_unit_i == `DEPM_PUNIT_MDEG || pos_unit_i == `DEPM_PUNIT_REV) &&
	                (spd_unit_i == `DEPM_VUNIT_MDEGS || spd_unit_i == `DEPM_VUNIT_REVS ||
	                 spd_unit_i == `DEPM_VUNIT_REVM)) :
	               (pos_unit_i == `DEPM_PUNIT_MM &&
	                (spd_unit_i == `DEPM_VUNIT_MMS || spd_unit_i == `DEPM_VUNIT_MS));

	// Channel one
	depm_channel #(.W(W)) u_ch1 (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n),
		.ce_i        (ce_i),
		.tick_i      (tick),
		.type_i      (s1_type_i),
		.fmt_i       (s1_fmt_i),
		.width_i     (s1_width_i),
		.dir_inv_i   (s1_dir_inv_i),
		.offset_i    (s1_offset_i),
		.pos_factor_i(s1_position_norm_factor_i),
		.pos_shift_i (s1_position_shift_exponent_i),
		.spd_factor_i(s1_speed_norm_factor_i),
		.spd_shift_i (s1_speed_shift_exponent_i),
		.filt_log2_i (filt_log2_i),
		.trk_a_i     (s1_trk_a_i),
		.trk_b_i     (s1_trk_b_i),
		.abs_word_i  (s1_abs_word_i),
		.pos_o       (c1_pos),
		.spd_o       (c1_spd)
	);

	// Channel two
	depm_channel #(.W(W)) u_ch2 (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n),
		.ce_i        (ce_i),
		.tick_i      (tick),
		.type_i      (s2_type_i),
		.fmt_i       (s2_fmt_i),
		.width_i     (s2_width_i),
		.dir_inv_i   (s2_dir_inv_i),
		.offset_i    (s2_offset_i),
		.pos_factor_i(s2_position_norm_factor_i),
		.pos_shift_i (s2_position_shift_exponent_i),
		.spd_factor_i(s2_speed_norm_factor_i),
		.spd_shift_i (s2_speed_shift_exponent_i),
		.filt_log2_i (filt_log2_i),
		.trk_a_i     (s2_trk_a_i),
		.trk_b_i     (s2_trk_b_i),
		.abs_word_i  (s2_abs_word_i),
		.pos_o       (c2_pos),
		.spd_o       (c2_spd)
	);

	// Process and reference selection
	wire [W-1:0] p_pos = swap ? c2_pos : c1_pos;
	wire [W-1:0] p_spd = swap ? c2_spd : c1_spd;
	wire [W-1:0] r_pos = swap ? c1_pos : c2_pos;
	wire [W-1:0] r_spd = swap ? c1_spd : c2_spd;

	// Limit 1.5 x max speed by shift and add; the W bit sum still wraps for large maxima
	wire [W-1:0] v_lim = max_speed_i + (max_speed_i >> 1);
	// Thresholds grow by max speed / 256 so higher speeds tolerate more
	wire [W-1:0] thr_p = thr_pos_i + (max_speed_i >> 8);
	wire [W-1:0] thr_v = thr_spd_i + (max_speed_i >> 8);

	// Fault conditions, sampled on the module cycle tick
	wire both_on  = (s1_type_i != `DEPM_TYPE_NONE) && (s2_type_i != `DEPM_TYPE_NONE);
	wire f_range  = pos_act && (p_pos[W-1] || p_pos > meas_length_i);
	wire f_speed  = depm_abs(p_spd) > max_speed_i;
	wire f_cons   = both_on && ((depm_abs(p_spd - r_spd) > thr_v) ||
	                (pos_act && depm_abs(p_pos - r_pos) > thr_p));
	wire f_cfg    = !unit_ok || (pos_proc_en_i && !(s1_abs || s2_abs));
	wire any_f    = f_range || f_speed || f_cons || f_cfg;

	// Monitor state: idle until first cycle, then run, alarm is terminal
	always @* begin
		next_state = state;
		case (state)
		`DEPM_ST_IDLE: begin
			if (tick)
				next_state = `DEPM_ST_RUN;
		end
		`DEPM_ST_RUN: begin
			if (tick && any_f)
				next_state = `DEPM_ST_ALARM;
		end
		`DEPM_ST_ALARM: begin
			next_state = `DEPM_ST_ALARM;
		end
		default: begin
			next_state = `DEPM_ST_ALARM;
		end
		endcase
	end

	// State and sticky fault causes; only reset leaves alarm
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state           <= `DEPM_ST_IDLE;
			err_range_o     <= 1'b0;
			err_overspeed_o <= 1'b0;
			err_consist_o   <= 1'b0;
			cfg_error_o     <= 1'b0;
		end else if (ce_i) begin
			state <= next_state;
			if (tick && state == `DEPM_ST_RUN) begin
				err_range_o     <= err_range_o | f_range;
				err_overspeed_o <= err_overspeed_o | f_speed;
				err_consist_o   <= err_consist_o | f_cons;
				cfg_error_o     <= cfg_error_o | f_cfg;
			end
		end
	end

	// Outputs; in alarm every safety output is held off
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			safe_out_o       <= {NOUT{1'b0}};
			proc_pos_o       <= {W{1'b0}};
			proc_spd_o       <= {W{1'b0}};
			spd_limit_o      <= {W{1'b0}};
			pos_mon_active_o <= 1'b0;
			sect_rotary_o    <= `DEPM_SECT_LINEAR;
			pos_unit_o       <= `DEPM_PUNIT_MM;
			spd_unit_o       <= `DEPM_VUNIT_MMS;
			alarm_o          <= 1'b0;
		end else if (ce_i) begin
			alarm_o          <= (next_state == `DEPM_ST_ALARM);
			safe_out_o       <= (next_state == `DEPM_ST_RUN) ? out_req_i
			                                                 : {NOUT{1'b0}};
			proc_pos_o       <= pos_act ? p_pos : {W{1'b0}};
			proc_spd_o       <= p_spd;
			spd_limit_o      <= v_lim;
			pos_mon_active_o <= pos_act;
			sect_rotary_o    <= sect_rotary_i;
			pos_unit_o       <= pos_unit_i;
			spd_unit_o       <= spd_unit_i;
		end
	end

endmodule // depm_monitor

//--- tb/depm_enc_model.sv
// Behavioural model of the two axis encoders
`timescale 1ns/10ps

module depm_enc_model #(
	parameter W = 32
) (
	// Control from the bench
	input  wire         clk_i,
	input  wire [1:0]   run_i,
	input  wire [1:0]   fmt_i,
	input  wire [W-1:0] abs_pos_i,
	// Encoder lines
	output wire [1:0]   a_o,
	output wire [1:0]   b_o,
	output reg  [W-1:0] abs_o
);
	reg [1:0] ph0 = 2'h0;
	reg [1:0] ph1 = 2'h0;

	initial abs_o = {W{1'b0}};
	// Gray phase, so only one track moves per step
	assign a_o = {ph1[1], ph0[1]};
	assign b_o = {ph1[1] ^ ph1[0], ph0[1] ^ ph0[0]};

	// One step a clock while running; a halted encoder holds its levels
	always @(negedge clk_i) begin
		if (run_i[0])
			ph0 <= ph0 + 2'h1;
		if (run_i[1])
			ph1 <= ph1 + 2'h1;
		abs_o <= (fmt_i == 2'h1) ? (abs_pos_i ^ (abs_pos_i >> 1)) : abs_pos_i;
	end
endmodule // depm_enc_model

//--- tb/depm_monitor_properties.sv
// Port assertions for the dual encoder plausibility monitor
`timescale 1ns/10ps
`include "depm_defines.vh"

module depm_monitor_checker #(
	parameter W          = 32,
	parameter NOUT       = 8,
	parameter CYCLE_CLKS = 10
) (
	// Clock and reset
	input wire            clk_i,
	input wire            rst_n_i,
	// Watched inputs
	input wire            pos_proc_en_i,
	input wire [W-1:0]    meas_length_i,
	input wire [W-1:0]    max_speed_i,
	input wire [2:0]      s1_type_i,
	input wire [2:0]      s2_type_i,
	// Watched outputs
	input wire [NOUT-1:0] safe_out_o,
	input wire [W-1:0]    proc_pos_o,
	input wire [W-1:0]    proc_spd_o,
	input wire [W-1:0]    spd_limit_o,
	input wire            pos_mon_active_o,
	input wire            alarm_o,
	input wire            err_range_o,
	input wire            err_overspeed_o,
	input wire            err_consist_o,
	input wire            cfg_error_o
);
	// Four module cycles plus reset sync slack
	localparam int LAT    = 4 * CYCLE_CLKS + 8;
	localparam int SETTLE = 3 * CYCLE_CLKS + 8;
	reg [7:0]   stab;
	reg [W-1:0] mx_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// Cycles with a steady maximum speed since reset release
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stab <= 8'h00;
			mx_q <= {W{1'b0}};
		end else begin
			mx_q <= max_speed_i;
			if (mx_q != max_speed_i)
				stab <= 8'h00;
			else if (stab != 8'hff)
				stab <= stab + 8'h01;
		end
	end

	// Trigger conditions
	sequence s_fast;
		$signed(proc_spd_o) > $signed(max_speed_i);
	endsequence
	sequence s_out;
		pos_mon_active_o && ($signed(proc_pos_o) < 0 || proc_pos_o > meas_length_i);
	endsequence
	sequence s_badcfg;
		pos_proc_en_i && s1_type_i != `DEPM_TYPE_ABS && s2_type_i != `DEPM_TYPE_ABS;
	endsequence

	AST_ALARM_OFF: assert property (alarm_o |-> safe_out_o == {NOUT{1'b0}})
		else $error("safe outputs on during alarm");
	AST_LATCH: assert property (alarm_o |=> alarm_o)
		else $error("alarm dropped before reset");
	AST_CAUSE: assert property ((err_range_o | err_overspeed_o | err_consist_o | cfg_error_o)
		|-> alarm_o)
		else $error("error flag without alarm");
	AST_POS_GATE: assert property (!pos_mon_active_o |-> proc_pos_o == {W{1'b0}})
		else $error("position reported while inactive");
	AST_LIMIT: assert property (stab == SETTLE |->
		spd_limit_o == max_speed_i + (max_speed_i >> 1))
		else $error("speed limit not one and a half of maximum");
	AST_OVERSPEED: assert property (s_fast |-> ##[0:LAT] err_overspeed_o)
		else $error("overspeed not flagged");
	AST_RANGE: assert property (s_out |-> ##[0:LAT] err_range_o)
		else $error("position outside length not flagged");
	AST_CFG: assert property (s_badcfg |-> ##[0:LAT] cfg_error_o)
		else $error("position enable without absolute sensor accepted");
endmodule // depm_monitor_checker

bind depm_monitor depm_monitor_checker #(.W(W), .NOUT(NOUT), .CYCLE_CLKS(CYCLE_CLKS))
	depm_monitor_checker_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.pos_proc_en_i(pos_proc_en_i), .meas_length_i(meas_length_i),
	.max_speed_i(max_speed_i), .s1_type_i(s1_type_i), .s2_type_i(s2_type_i),
	.safe_out_o(safe_out_o), .proc_pos_o(proc_pos_o), .proc_spd_o(proc_spd_o),
	.spd_limit_o(spd_limit_o), .pos_mon_active_o(pos_mon_active_o), .alarm_o(alarm_o),
	.err_range_o(err_range_o), .err_overspeed_o(err_overspeed_o),
	.err_consist_o(err_consist_o), .cfg_error_o(cfg_error_o));

//--- tb/tb_top.sv
// Self-checking testbench for the dual encoder plausibility monitor
`timescale 1ns/10ps
`include "depm_defines.vh"

module tb_top;
	// Stimulus, valued at time zero
	reg         clk = 1'b0;
	reg         rst_n = 1'b0;
	reg         rot = 1'b1;
	reg  [1:0]  punit = 2'h1;
	reg  [2:0]  vunit = 3'h4;
	reg         pen = 1'b0;
	reg  [31:0] mx = 32'h400;
	reg  [2:0]  t1 = 3'h1;
	reg  [2:0]  t2 = 3'h1;
	reg  [1:0]  fmt = 2'h0;
	reg         dinv = 1'b0;
	reg  [7:0]  req = 8'h00;
	reg  [1:0]  run = 2'h0;
	reg  [31:0] apos = 32'h5a;
	reg         ce = 1'b1;
	reg  [31:0] mlen = 32'h64;
	reg  [31:0] thp = 32'hffff;
	reg  [31:0] thv = 32'h1;
	reg  [2:0]  flt = 3'h0;
	reg  [5:0]  wd = 6'h0;
	reg  [31:0] offs = 32'h5;
	reg  [15:0] pf = 16'h1;
	reg  [4:0]  psh = 5'h0;
	reg  [15:0] vf = 16'h3;
	reg  [4:0]  vsh = 5'h1;
	reg  [31:0] seed = 32'h1ba836af;
	reg  [31:0] s;
	reg         seen = 1'b0;
	reg  [3:0]  notes [$];
	integer     fail_count = 0;
	integer     cmp_count = 0;
	integer     cyc = 0;
	integer     i;
	wire [1:0]  a;
	wire [1:0]  b;
	wire [31:0] aw;
	wire [7:0]  sout;
	wire [31:0] ppos;
	wire [31:0] pspd;
	wire [31:0] lim;
	wire        pact;
	wire        rot_o;
	wire [1:0]  pu_o;
	wire [2:0]  vu_o;
	wire        alarm;
	wire [3:0]  errs;

	initial forever #50 clk = ~clk;

	depm_enc_model #(.W(32)) depm_enc_model_inst (.clk_i(clk), .run_i(run), .fmt_i(fmt),
		.abs_pos_i(apos), .a_o(a), .b_o(b), .abs_o(aw));

	depm_monitor #(.W(32), .NOUT(8), .CYCLE_CLKS(10)) depm_monitor_inst (
		.clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .sect_rotary_i(rot),
		.pos_unit_i(punit), .spd_unit_i(vunit), .pos_proc_en_i(pen),
		.meas_length_i(mlen), .max_speed_i(mx), .thr_pos_i(thp),
		.thr_spd_i(thv), .filt_log2_i(flt), .s1_type_i(t1), .s1_fmt_i(fmt),
		.s1_width_i(wd), .s1_dir_inv_i(dinv), .s1_offset_i(offs),
		.s1_position_norm_factor_i(pf), .s1_position_shift_exponent_i(psh),
		.s1_speed_norm_factor_i(vf), .s1_speed_shift_exponent_i(vsh),
		.s2_type_i(t2), .s2_fmt_i(fmt), .s2_width_i(wd), .s2_dir_inv_i(dinv),
		.s2_offset_i(offs), .s2_position_norm_factor_i(pf),
		.s2_position_shift_exponent_i(psh), .s2_speed_norm_factor_i(vf),
		.s2_speed_shift_exponent_i(vsh), .s1_trk_a_i(a[0]), .s1_trk_b_i(b[0]),
		.s1_abs_word_i(aw), .s2_trk_a_i(a[1]), .s2_trk_b_i(b[1]), .s2_abs_word_i(aw),
		.out_req_i(req), .safe_out_o(sout), .proc_pos_o(ppos), .proc_spd_o(pspd),
		.spd_limit_o(lim), .pos_mon_active_o(pact), .sect_rotary_o(rot_o),
		.pos_unit_o(pu_o), .spd_unit_o(vu_o), .alarm_o(alarm), .err_range_o(errs[3]),
		.err_overspeed_o(errs[2]), .err_consist_o(errs[1]), .cfg_error_o(errs[0]));

	task check(input [31:0] seen_v, input [31:0] exp_v);
		begin
			cmp_count = cmp_count + 1;
			if (seen_v !== exp_v) begin
				fail_count = fail_count + 1;
				$display("BAD t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
			end
		end
	endtask

	task print_verdict;
		begin
			check(notes.size(), 0);
			$display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
			if (fail_count == 0 && cmp_count > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask

	// Release reset with a new sensor setup; caller already holds reset
	task go(input [2:0] x1, input [2:0] x2, input p, input [1:0] r);
		begin
			t1 = x1;
			t2 = x2;
			pen = p;
			run = r;
			repeat (6) @(negedge clk);
			rst_n = 1'b1;
		end
	endtask

	// Extra edge lets the watcher take its note before any reset
	task wait_alarm;
		integer n;
		begin
			n = 0;
			while (alarm !== 1'b1 && n < 600) begin
				@(negedge clk);
				n = n + 1;
			end
			@(negedge clk);
			check(alarm, 1'b1);
		end
	endtask

	// Each alarm takes the oldest expected cause set
	always @(posedge clk) begin
		if (!rst_n)
			seen <= 1'b0;
		else if (alarm === 1'b1 && !seen) begin
			seen <= 1'b1;
			if (notes.size() == 0)
				check({28'h0, errs}, 32'hf0);
			else
				check({28'h0, errs}, {28'h0, notes.pop_front()});
		end
	end

	// Hang guard, well above the run length
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			fail_count = fail_count + 1;
			print_verdict;
		end
	end

	initial begin
		mx = ($random(seed) & 32'h0fffffff) | 32'h400;
		req = $random(seed);
		go(3'h1, 3'h1, 1'b0, 2'h3);
		repeat (300) @(negedge clk);
		s = pspd;
		check(alarm, 1'b0);
		check(sout, req);
		check(lim, mx + (mx >> 1));
		check(ppos, 32'h0);
		check({rot_o, pu_o, vu_o}, 6'h2c);
		check(s[31] ? -s : s, 32'hf);
		dinv = 1'b1;
		repeat (100) @(negedge clk);
		check(pspd, -s);
		// Encoders halted first so no track edge is lost while frozen
		run = 2'h0;
		ce = 1'b0;
		s = pspd;
		repeat (50) @(negedge clk);
		check(pspd, s);
		check(sout, req);
		ce = 1'b1;
		run = 2'h3;
		repeat (30) @(negedge clk);
		check(alarm, 1'b0);
		$display("T1 normal run done");
		// Overspeed, channels in step
		rst_n = 1'b0;
		mx = 32'h4;
		dinv = 1'b0;
		notes.push_back(4'h4);
		go(3'h1, 3'h1, 1'b0, 2'h3);
		wait_alarm;
		check(sout, 8'h00);
		$display("T2 overspeed done");
		// Reference encoder stands still; scaled threshold is 5
		rst_n = 1'b0;
		mx = 32'h400;
		notes.push_back(4'h2);
		go(3'h1, 3'h1, 1'b0, 2'h1);
		wait_alarm;
		$display("T3 consistency done");
		// Position enable without absolute sensor, then mdeg on linear
		for (i = 0; i < 2; i = i + 1) begin
			rst_n = 1'b0;
			rot = (i == 0);
			notes.push_back(4'h1);
			go(3'h1, 3'h1, i == 0, 2'h0);
			wait_alarm;
		end
		$display("T4 configuration done");
		// Absolute process channel in range, then past the length
		for (i = 0; i < 3; i = i + 1) begin
			rst_n = 1'b0;
			rot = 1'b0;
			punit = 2'h0;
			vunit = 3'h1;
			mx = 32'h10000;
			fmt = (i == 1) ? 2'h1 : 2'h0;
			apos = 32'h5a;
			notes.push_back(4'h8);
			go((i == 2) ? 3'h1 : 3'h3, (i == 2) ? 3'h3 : 3'h0, 1'b1, 2'h0);
			repeat (60) @(negedge clk);
			check(ppos, 32'h5f);
			check({pact, rot_o, pu_o, vu_o}, 7'h41);
			apos = 32'hc8;
			wait_alarm;
		end
		$display("T5 absolute range done");
		print_verdict;
	end
endmodule // tb_top
